// ### shared/adc_fmt_pkg.sv
// Constants and types shared by the sample output formatter design
package adc_fmt_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned QUIET_TIME_NS = 1000;
  localparam int unsigned QUIET_CYCLES  = (QUIET_TIME_NS / CLK_PERIOD_NS > 0) ?
                                          QUIET_TIME_NS / CLK_PERIOD_NS : 1;
  localparam int unsigned QUIET_W       = 8;

  // ----------------------------------------------------------------
  // Sample coding
  // ----------------------------------------------------------------
  localparam int unsigned CODE_W   = 8;
  localparam logic [7:0]  CODE_MIN = 8'h00;
  localparam logic [7:0]  CODE_MAX = 8'hff;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATE  = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] OFS_IRQ_MK = 8'h0c;
  localparam logic [7:0] OFS_COUNT  = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EDGE_LSB = 0;
  localparam int unsigned CTRL_EDGE_W   = 2;
  localparam logic [1:0]  EDGE_AUTO     = 2'h0;
  localparam logic [1:0]  EDGE_TRUE_UP  = 2'h1;
  localparam logic [1:0]  EDGE_INV_DN   = 2'h2;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;

  localparam int unsigned ST_CODE_LSB   = 0;
  localparam int unsigned ST_FLAG_BIT   = 8;
  localparam int unsigned ST_TRUE_BIT   = 9;
  localparam int unsigned ST_INV_BIT    = 10;
  localparam int unsigned ST_MODE_LSB   = 12;

  localparam int unsigned IRQ_SAMPLE    = 0;
  localparam int unsigned IRQ_RANGE     = 1;
  localparam int unsigned IRQ_W         = 2;
  localparam logic [1:0]  IRQ_MK_RESET  = 2'h0;

  // ----------------------------------------------------------------
  // Sampling edge modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_IDLE    = 4'b0001,
    MODE_TRUE_UP = 4'b0010,
    MODE_INV_DN  = 4'b0100,
    MODE_DIFF    = 4'b1000
  } edge_mode_t;

endpackage

// ### src/sync_stage.sv
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sync_stage #(
  parameter int unsigned WIDTH = 1
) (
  // Clock
  input  wire logic             mclk,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // Not reset: after release the stages already hold real pin levels,
  // so no false edge or wrong coding appears downstream
  always_ff @(posedge mclk) begin
    meta     <= async_in;
    sync_out <= meta;
  end

endmodule

// ### src/adc_sample_output_formatter.sv
// Sample clock edge selection, output coding and range flag with AHB-Lite control
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module adc_sample_output_formatter
  import adc_fmt_pkg::*;
#(
  parameter int unsigned QUIET_LIMIT = QUIET_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Sample clock pins
  input  wire logic        clk_true,
  input  wire logic        clk_inv,
  // Quantiser result pins
  input  wire logic [7:0]  quant_code,
  input  wire logic        quant_under,
  input  wire logic        quant_over,
  // Mode pins
  input  wire logic        coding_select_n,
  input  wire logic        output_enable_n,
  // Sample outputs
  output logic      [7:0]  sample_code_bits,
  output logic             sample_code_oe_n,
  output logic             range_exceeded_flag,
  output logic             range_flag_oe_n,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned PIN_W = 14;

  logic [PIN_W-1:0] pins_sync;
  logic             s_clk_true;
  logic             s_clk_inv;
  logic [7:0]       s_code;
  logic             s_under;
  logic             s_over;
  logic             s_tc_n;
  logic             s_oe_n;

  sync_stage #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .mclk     (mclk),
    .async_in ({clk_true, clk_inv, quant_code, quant_under, quant_over,
                coding_select_n, output_enable_n}),
    .sync_out (pins_sync)
  );

  assign s_clk_true = pins_sync[13];
  assign s_clk_inv  = pins_sync[12];
  assign s_code     = pins_sync[11:4];
  assign s_under    = pins_sync[3];
  assign s_over     = pins_sync[2];
  assign s_tc_n     = pins_sync[1];
  assign s_oe_n     = pins_sync[0];

  // ----------------------------------------------------------------
  // Clock edge detection
  // ----------------------------------------------------------------
  logic prev_true;
  logic prev_inv;
  logic true_rise;
  logic true_toggle;
  logic inv_fall;
  logic inv_toggle;

  // Follows the pins through reset too, so release brings no false edge
  always_ff @(posedge mclk) begin
    prev_true <= s_clk_true;
    prev_inv  <= s_clk_inv;
  end

  assign true_rise   = s_clk_true & ~prev_true;
  assign true_toggle = s_clk_true ^ prev_true;
  assign inv_fall    = ~s_clk_inv & prev_inv;
  assign inv_toggle  = s_clk_inv ^ prev_inv;

  // ----------------------------------------------------------------
  // Activity watch: an input is quiet after QUIET_LIMIT idle cycles
  // ----------------------------------------------------------------
  logic [QUIET_W-1:0] true_idle;
  logic [QUIET_W-1:0] inv_idle;
  logic               true_active;
  logic               inv_active;
  localparam logic [QUIET_W-1:0] IDLE_TOP = QUIET_W'(QUIET_LIMIT);

  always_ff @(posedge mclk) begin
    if (reset) begin
      true_idle <= IDLE_TOP;
    end else if (true_toggle) begin
      true_idle <= '0;
    end else if (true_idle != IDLE_TOP) begin
      true_idle <= true_idle + QUIET_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      inv_idle <= IDLE_TOP;
    end else if (inv_toggle) begin
      inv_idle <= '0;
    end else if (inv_idle != IDLE_TOP) begin
      inv_idle <= inv_idle + QUIET_W'(1);
    end
  end

  assign true_active = (true_idle != IDLE_TOP);
  assign inv_active  = (inv_idle != IDLE_TOP);

  // ----------------------------------------------------------------
  // Edge mode state machine
  // ----------------------------------------------------------------
  logic [1:0] edge_sel;
  edge_mode_t mode;
  edge_mode_t next_mode;
  logic       sample_strobe;

  always_comb begin
    next_mode = MODE_IDLE;
    if (edge_sel == EDGE_TRUE_UP) begin
      next_mode = MODE_TRUE_UP;
    end else if (edge_sel == EDGE_INV_DN) begin
      next_mode = MODE_INV_DN;
    end else if (true_active && inv_active) begin
      next_mode = MODE_DIFF;
    end else if (true_active) begin
      next_mode = MODE_TRUE_UP;
    end else if (inv_active) begin
      next_mode = MODE_INV_DN;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode <= MODE_IDLE;
    end else begin
      mode <= next_mode;
    end
  end

  always_comb begin
    case (mode)
      MODE_TRUE_UP: sample_strobe = true_rise;
      MODE_INV_DN:  sample_strobe = inv_fall;
      MODE_DIFF:    sample_strobe = true_rise;
      default:      sample_strobe = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sample capture with saturation
  // ----------------------------------------------------------------
  logic [7:0]  held_code;
  logic        held_flag;
  logic [7:0]  next_code;
  logic [31:0] sample_count;

  always_comb begin
    next_code = s_code;
    if (s_under) begin
      next_code = CODE_MIN;
    end else if (s_over) begin
      next_code = CODE_MAX;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      held_code <= CODE_MIN;
      held_flag <= 1'b0;
    end else if (sample_strobe) begin
      held_code <= next_code;
      held_flag <= s_under | s_over;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sample_count <= '0;
    end else if (sample_strobe) begin
      sample_count <= sample_count + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Output coding and drive
  // ----------------------------------------------------------------
  // Code and flag leave in the same cycle so a reader always sees a
  // matching pair; capture timing relative to the sample edge is up to
  // the reader.
  always_ff @(posedge mclk) begin
    if (reset) begin
      sample_code_bits    <= CODE_MIN;
      range_exceeded_flag <= 1'b0;
      sample_code_oe_n    <= 1'b1;
      range_flag_oe_n     <= 1'b1;
    end else begin
      sample_code_bits    <= {held_code[7] ^ ~s_tc_n, held_code[6:0]};
      range_exceeded_flag <= held_flag;
      sample_code_oe_n    <= s_oe_n;
      range_flag_oe_n     <= s_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite address phase
  // ----------------------------------------------------------------
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       rd_take;
  logic       addr_hit_hi;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_take   = hsel & htrans[1] & hready & ~hwrite;
  assign addr_hit_hi = (haddr[31:8] != 24'h000000);

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel & htrans[1] & hready & hwrite & ~addr_hit_hi;
      wr_addr <= haddr[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Control and interrupt registers
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;

  assign irq_event   = {sample_strobe & (s_under | s_over), sample_strobe};
  assign irq_clear   = (wr_pend && wr_addr == OFS_IRQ_ST) ? hwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (reset) begin
      edge_sel <= CTRL_RESET;
    end else if (wr_pend && wr_addr == OFS_CTRL) begin
      edge_sel <= hwdata[CTRL_EDGE_LSB +: CTRL_EDGE_W];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_mask <= IRQ_MK_RESET;
    end else if (wr_pend && wr_addr == OFS_IRQ_MK) begin
      irq_mask <= hwdata[IRQ_W-1:0];
    end
  end

  // A new event in the clearing cycle keeps its bit set
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_status & ~irq_clear | irq_event) & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered in the address phase
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr[7:0] == OFS_CTRL && !addr_hit_hi) begin
      next_rdata[CTRL_EDGE_LSB +: CTRL_EDGE_W] = edge_sel;
    end else if (haddr[7:0] == OFS_STATE) begin
      next_rdata[ST_CODE_LSB +: CODE_W] = held_code;
      next_rdata[ST_FLAG_BIT]           = held_flag;
      next_rdata[ST_TRUE_BIT]           = true_active;
      next_rdata[ST_INV_BIT]            = inv_active;
      next_rdata[ST_MODE_LSB +: 4]      = mode;
    end else if (haddr[7:0] == OFS_IRQ_ST) begin
      next_rdata[IRQ_W-1:0] = irq_status;
    end else if (haddr[7:0] == OFS_IRQ_MK) begin
      next_rdata[IRQ_W-1:0] = irq_mask;
    end else if (haddr[7:0] == OFS_COUNT) begin
      next_rdata = sample_count;
    end
    if (addr_hit_hi) begin
      next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= next_rdata;
    end
  end

endmodule

// ### tb/capture_model.sv
// Downstream capture model latching driven output words
`timescale 1ns/1ps
module capture_model (
  // Clock
  input  wire logic       mclk,
  // Formatter outputs
  input  wire logic [7:0] sample_code_bits,
  input  wire logic       sample_code_oe_n,
  input  wire logic       range_exceeded_flag,
  input  wire logic       range_flag_oe_n,
  // Captured word
  output logic      [7:0] cap_code,
  output logic            cap_flag
);
  // Capture a cycle after the outputs settle, only while both are driven
  always_ff @(posedge mclk) begin
    if (!sample_code_oe_n && !range_flag_oe_n) begin
      cap_code <= sample_code_bits;
      cap_flag <= range_exceeded_flag;
    end
  end
endmodule

// ### tb/adc_fmt_chk.sv
// Port checker for the sample output formatter
`timescale 1ns/1ps
module adc_fmt_chk
  import adc_fmt_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // Pins
  input wire logic       clk_true,
  input wire logic       clk_inv,
  input wire logic       coding_select_n,
  input wire logic       output_enable_n,
  // Outputs
  input wire logic [7:0] sample_code_bits,
  input wire logic       sample_code_oe_n,
  input wire logic       range_exceeded_flag,
  input wire logic       range_flag_oe_n,
  input wire logic       irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_quiet;
    $stable(clk_true) && $stable(clk_inv) && $stable(coding_select_n);
  endsequence

  property p_oe_drive;
    (!output_enable_n)[*6] |-> !sample_code_oe_n;
  endproperty
  property p_oe_rel;
    (output_enable_n)[*6] |-> sample_code_oe_n;
  endproperty
  property p_oe_pair;
    sample_code_oe_n == range_flag_oe_n;
  endproperty
  property p_sat_bin;
    (coding_select_n)[*6] ##0 range_exceeded_flag |->
      sample_code_bits inside {CODE_MIN, CODE_MAX};
  endproperty
  property p_sat_twos;
    (!coding_select_n)[*6] ##0 range_exceeded_flag |->
      sample_code_bits inside {8'h80, 8'h7f};
  endproperty
  property p_msb;
    $changed(coding_select_n) ##1 s_quiet [*5] |->
      sample_code_bits[7] != $past(sample_code_bits[7], 5);
  endproperty
  property p_hold;
    s_quiet [*8] |-> $stable(sample_code_bits) && $stable(range_exceeded_flag);
  endproperty
  property p_rel;
    $fell(reset) |-> sample_code_oe_n && range_flag_oe_n && !irq;
  endproperty

  a_oe_drive: assert property (p_oe_drive)
    else $error("outputs released while enabled");
  a_oe_rel: assert property (p_oe_rel)
    else $error("outputs driven while disabled");
  a_oe_pair: assert property (p_oe_pair)
    else $error("code and flag enables differ");
  a_sat_bin: assert property (p_sat_bin)
    else $error("binary code not saturated");
  a_sat_twos: assert property (p_sat_twos)
    else $error("twos complement code not saturated");
  a_msb: assert property (p_msb)
    else $error("coding change did not flip top bit");
  a_hold: assert property (p_hold)
    else $error("outputs changed without a sample");
  a_rel: assert property (p_rel)
    else $error("outputs not released after reset");

  c_flag: cover property ($rose(range_exceeded_flag));
  c_irq: cover property ($rose(irq));
  c_off: cover property ($rose(sample_code_oe_n));
endmodule

bind adc_sample_output_formatter adc_fmt_chk u_chk (.mclk, .reset, .clk_true, .clk_inv,
  .coding_select_n, .output_enable_n, .sample_code_bits, .sample_code_oe_n,
  .range_exceeded_flag, .range_flag_oe_n, .irq);

// ### tb/tb_top.sv
// Self-checking testbench for the sample output formatter
`timescale 1ns/1ps
module tb_top;
  import adc_fmt_pkg::*;
  logic        mclk = 0, reset = 1, hsel = 0, hwrite = 0, hready;
  logic        clk_true = 0, clk_inv = 1, quant_under = 0, quant_over = 0;
  logic        coding_select_n = 1, output_enable_n = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [7:0]  quant_code = 0, sample_code_bits, cap_code;
  logic        hreadyout, hresp, sample_code_oe_n, range_exceeded_flag;
  logic        range_flag_oe_n, irq, cap_flag;
  int          err_total = 0, compares = 0;

  assign hready = hreadyout;
  always #10 mclk = ~mclk;

  adc_sample_output_formatter #(.QUIET_LIMIT(8)) dut (.mclk, .reset, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .clk_true,
    .clk_inv, .quant_code, .quant_under, .quant_over, .coding_select_n, .output_enable_n,
    .sample_code_bits, .sample_code_oe_n, .range_exceeded_flag, .range_flag_oe_n, .irq);
  capture_model u_cap (.mclk, .sample_code_bits, .sample_code_oe_n, .range_exceeded_flag,
    .range_flag_oe_n, .cap_code, .cap_flag);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] fmt(input logic [7:0] c, input logic un, ov, bin);
    logic [7:0] v;
    v = un ? CODE_MIN : (ov ? CODE_MAX : c);
    return bin ? v : {~v[7], v[6:0]};
  endfunction

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
    chk("response", 32'h0, hresp);
  endtask

  // Mode 0 true pin, 1 inverted pin, 2 both; a decoy follows each active edge
  task automatic run(input int m, input logic [7:0] c, input logic un, ov);
    for (int i = 0; i < 3; i++) begin
      quant_code <= c;
      quant_under <= un;
      quant_over <= ov;
      ticks(3);
      if (m != 1) clk_true <= 1'b1;
      if (m != 0) clk_inv <= 1'b0;
      ticks(4);
      clk_true <= 1'b0;
      clk_inv <= 1'b1;
      quant_code <= ~c;
      quant_under <= 1'b0;
      quant_over <= 1'b0;
      ticks(3);
    end
  endtask

  task automatic expect_out(input logic [7:0] c, input logic un, ov);
    chk("code", fmt(c, un, ov, coding_select_n), sample_code_bits);
    chk("flag", un | ov, range_exceeded_flag);
    chk("captured code", fmt(c, un, ov, coding_select_n), cap_code);
    chk("captured flag", un | ov, cap_flag);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_codes;
    logic [7:0] tbl [5] = '{8'h00, 8'h01, 8'hfe, 8'hff, 8'h5a};
    for (int b = 1; b >= 0; b--) begin
      coding_select_n <= b[0];
      for (int j = 0; j < 5; j++) begin
        run(0, tbl[j], 1'b0, 1'b0);
        expect_out(tbl[j], 1'b0, 1'b0);
      end
    end
    coding_select_n <= 1'b1;
    ticks(6);
    expect_out(8'h5a, 1'b0, 1'b0);
  endtask

  task automatic t_range;
    for (int b = 1; b >= 0; b--) begin
      coding_select_n <= b[0];
      for (int k = 1; k < 4; k++) begin
        run(0, 8'h40, k[0], k[1]);
        expect_out(8'h40, k[0], k[1]);
      end
    end
  endtask

  task automatic t_modes;
    ticks(20);
    run(1, 8'h3c, 1'b0, 1'b0);
    expect_out(8'h3c, 1'b0, 1'b0);
    ticks(20);
    run(2, 8'hc3, 1'b0, 1'b0);
    expect_out(8'hc3, 1'b0, 1'b0);
    ticks(20);
    ahb(1'b1, OFS_CTRL, EDGE_INV_DN, rd);
    ahb(1'b0, OFS_CTRL, 0, rd);
    chk("edge select", EDGE_INV_DN, rd);
    run(0, 8'h11, 1'b0, 1'b0);
    expect_out(8'hc3, 1'b0, 1'b0);
    ahb(1'b1, OFS_CTRL, EDGE_AUTO, rd);
  endtask

  task automatic t_oe;
    output_enable_n <= 1'b1;
    coding_select_n <= 1'b0;
    ticks(6);
    chk("code enable", 1'b1, sample_code_oe_n);
    chk("flag enable", 1'b1, range_flag_oe_n);
    output_enable_n <= 1'b0;
    ticks(6);
    chk("code enable", 1'b0, sample_code_oe_n);
    expect_out(8'hc3, 1'b0, 1'b0);
  endtask

  task automatic t_irq;
    ahb(1'b0, OFS_IRQ_MK, 0, rd);
    chk("mask reset", IRQ_MK_RESET, rd);
    ahb(1'b0, OFS_IRQ_ST, 0, rd);
    chk("status", 2'h3, rd);
    chk("irq masked", 1'b0, irq);
    ahb(1'b1, OFS_IRQ_MK, 32'h1, rd);
    ticks(3);
    chk("irq raised", 1'b1, irq);
    ahb(1'b1, OFS_IRQ_ST, 32'h3, rd);
    ticks(3);
    chk("irq cleared", 1'b0, irq);
    ahb(1'b0, OFS_IRQ_ST, 0, rd);
    chk("status cleared", 0, rd);
    ahb(1'b0, 32'h40, 0, rd);
    chk("unmapped", 0, rd);
    ahb(1'b1, 32'h10c, 32'h3, rd);
    ahb(1'b0, OFS_IRQ_MK, 0, rd);
    chk("mask kept", 32'h1, rd);
    ahb(1'b0, OFS_STATE, 0, rd);
    chk("state", 32'h0000_10c3, rd);
    ahb(1'b0, OFS_COUNT, 0, rd);
    chk("sample count", 32'h32, rd);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    ticks(12);
    reset <= 1'b0;
    ticks(2);
    t_codes();
    t_range();
    t_modes();
    t_oe();
    t_irq();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    wrap_up();
  end
endmodule
